// ==== dual_prescaled_counter_timers.sv ====
// dual_prescaled_counter_timers: two prescaled 8-bit down-counters behind
// an apb slave, with sticky interrupt status, mask and one irq line.
// assumes apb3 master on pclk; external_timer_input synchronous to pclk.
//
// Functional notes
// - two counters, 8-bit each, 6-bit prescalers
// - unit a internal only; unit b selectable
// - prescaler divides source by 1 to 64
// - counter decrements once per prescaler pulse
// - terminal count raises that unit's interrupt
// - software starts, stops, resumes or reloads
// - single-pass halts at zero; continuous reloads
// - counter readable undisturbed; prescalers not readable
// - unit b source: pclk/4 or external input
// - external input: clock, trigger (two kinds), gate
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module dual_prescaled_counter_timers
    import dual_timer_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int PRE_W = 6,
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_timer_input,
    output logic counter_a_interrupt,
    output logic counter_b_interrupt,
    output logic irq
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        reg_hit = (addr == ADDR_W'({idx, 2'b00}));
    endfunction : reg_hit

    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        mapped = reg_hit(addr, IDX_TIMER_MODE)
            || reg_hit(addr, IDX_COUNTER_B)
            || reg_hit(addr, IDX_PRESCALER_B)
            || reg_hit(addr, IDX_COUNTER_A)
            || reg_hit(addr, IDX_PRESCALER_A)
            || reg_hit(addr, IDX_INT_STATUS)
            || reg_hit(addr, IDX_INT_MASK);
    endfunction : mapped

    logic [7:0] timer_mode_r;
    logic [7:0] prescaler_a_r;
    logic [7:0] prescaler_b_r;
    logic [CNT_W-1:0] init_a_r;
    logic [CNT_W-1:0] init_b_r;
    logic [1:0] int_status_r;
    logic [1:0] int_mask_r;
    logic [31:0] prdata_r;
    logic [1:0] div_cnt_r;
    logic [31:0] rd_nxt;

    logic setup;
    logic wr;
    logic wr_tm;
    logic restart_a;
    logic restart_b_sw;
    logic restart_b_trig;
    logic int_tick;
    logic src_tick_b;
    logic eoc_a;
    logic eoc_b;
    logic cont_a;
    logic cont_b;
    logic en_a;
    logic en_b;
    logic use_ext_b;
    logic trig_mode_b;
    logic [1:0] in_mode;
    logic [CNT_W-1:0] count_a;
    logic [CNT_W-1:0] count_b;
    logic wr_pre_a;
    logic wr_pre_b;
    logic wr_cnt_a;
    logic wr_cnt_b;
    logic wr_status;
    logic wr_mask;
    logic [1:0] status_clr;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign wr_tm = wr && reg_hit(paddr, IDX_TIMER_MODE);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = prdata_r;

    // ------------------------------------------------------------
    // register write strobes
    // ------------------------------------------------------------
    // each strobe lasts one access cycle, since pready is tied high
    assign wr_pre_a = wr && reg_hit(paddr, IDX_PRESCALER_A);
    assign wr_pre_b = wr && reg_hit(paddr, IDX_PRESCALER_B);
    assign wr_cnt_a = wr && reg_hit(paddr, IDX_COUNTER_A);
    assign wr_cnt_b = wr && reg_hit(paddr, IDX_COUNTER_B);
    assign wr_status = wr && reg_hit(paddr, IDX_INT_STATUS);
    assign wr_mask = wr && reg_hit(paddr, IDX_INT_MASK);
    // only written ones clear; a zero leaves a pending flag alone
    assign status_clr = wr_status ? pwdata[1:0] : 2'h0;

    // ------------------------------------------------------------
    // field views
    // ------------------------------------------------------------
    assign en_a = timer_mode_r[TM_EN_A];
    assign en_b = timer_mode_r[TM_EN_B];
    assign in_mode = timer_mode_r[TM_INMODE_MSB:TM_INMODE_LSB];
    assign cont_a = prescaler_a_r[PRE_CONT_BIT];
    assign cont_b = prescaler_b_r[PRE_CONT_BIT];
    assign use_ext_b = !prescaler_b_r[PRE_CLKSEL_BIT];
    assign trig_mode_b = !use_ext_b && (in_mode == 2'(in_trig_nonretrig) || in_mode == 2'(in_trig_retrig));

    // a load bit is a command: it fires once and never reads back
    assign restart_a = wr_tm && pwdata[TM_LOAD_A];
    assign restart_b_sw = wr_tm && pwdata[TM_LOAD_B];

    // ------------------------------------------------------------
    // internal clock divider
    // ------------------------------------------------------------
    // free-running from reset: a load lands anywhere in the tick phase, so
    // the first tick follows in 1 to 4 cycles and a period is exact to one tick
    assign int_tick = (div_cnt_r == 2'(INT_CLOCK_DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // timer_mode register
    // ------------------------------------------------------------
    // in single-pass, a unit halts by dropping its enable; a trigger
    // unit keeps its enable so the next edge can start it again;
    // a software write in the cycle of a terminal count wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_mode_r <= TIMER_MODE_RST;
        end else if (wr_tm) begin
            timer_mode_r <= pwdata[7:0] & ~(8'h01 << TM_LOAD_A) & ~(8'h01 << TM_LOAD_B);
        end else begin
            if (eoc_a && !cont_a) begin
                timer_mode_r[TM_EN_A] <= 1'b0;
            end
            if (eoc_b && !cont_b && !trig_mode_b) begin
                timer_mode_r[TM_EN_B] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // prescaler and initial count registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescaler_a_r <= PRESCALER_RST;
            prescaler_b_r <= PRESCALER_RST;
        end else begin
            if (wr_pre_a) begin
                prescaler_a_r <= pwdata[7:0];
            end
            if (wr_pre_b) begin
                prescaler_b_r <= pwdata[7:0];
            end
        end
    end

    // a write sets the reload value only; the live count moves on a load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_a_r <= COUNTER_INIT_RST;
            init_b_r <= COUNTER_INIT_RST;
        end else begin
            if (wr_cnt_a) begin
                init_a_r <= pwdata[CNT_W-1:0];
            end
            if (wr_cnt_b) begin
                init_b_r <= pwdata[CNT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // counter units
    // ------------------------------------------------------------
    prescaled_counter #(
        .CNT_W(CNT_W),
        .PRE_W(PRE_W)
    ) u_unit_a (
        .pclk(pclk),
        .presetn(presetn),
        .src_tick(int_tick),
        .run(en_a),
        .restart(restart_a),
        .continuous(cont_a),
        .init_count(init_a_r),
        .pre_ratio(prescaler_a_r[PRE_RATIO_MSB:PRE_RATIO_LSB]),
        .count(count_a),
        .eoc(eoc_a)
    );

    // external clock select overrides the input mode for unit b
    ext_input_cond u_ext_cond (
        .pclk(pclk),
        .presetn(presetn),
        .ext_in(external_timer_input),
        .int_tick(int_tick),
        .use_ext(use_ext_b),
        .mode(in_mode),
        .enable(en_b),
        .eoc(eoc_b),
        .continuous(cont_b),
        .src_tick(src_tick_b),
        .restart(restart_b_trig)
    );

    prescaled_counter #(
        .CNT_W(CNT_W),
        .PRE_W(PRE_W)
    ) u_unit_b (
        .pclk(pclk),
        .presetn(presetn),
        .src_tick(src_tick_b),
        .run(en_b),
        .restart(restart_b_sw || restart_b_trig),
        .continuous(cont_b),
        .init_count(init_b_r),
        .pre_ratio(prescaler_b_r[PRE_RATIO_MSB:PRE_RATIO_LSB]),
        .count(count_b),
        .eoc(eoc_b)
    );

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    // a terminal count in the clearing cycle survives: set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_r <= INT_RST;
        end else begin
            int_status_r <= (int_status_r & ~status_clr) | {eoc_b, eoc_a};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_r <= INT_RST;
        end else if (wr_mask) begin
            int_mask_r <= pwdata[1:0];
        end
    end

    // the unit lines show status unmasked; only irq honours the mask
    assign counter_a_interrupt = int_status_r[INT_A_BIT];
    assign counter_b_interrupt = int_status_r[INT_B_BIT];
    assign irq = |(int_status_r & int_mask_r);

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // sampled in the setup cycle so prdata is a flop in the access cycle;
    // a count can move between the two, which is harmless for a snapshot
    always_comb begin
        rd_nxt = 32'h0;
        if (reg_hit(paddr, IDX_TIMER_MODE)) begin
            rd_nxt[7:0] = timer_mode_r;
        end else if (reg_hit(paddr, IDX_COUNTER_A)) begin
            rd_nxt[CNT_W-1:0] = count_a;
        end else if (reg_hit(paddr, IDX_COUNTER_B)) begin
            rd_nxt[CNT_W-1:0] = count_b;
        end else if (reg_hit(paddr, IDX_INT_STATUS)) begin
            rd_nxt[1:0] = int_status_r;
        end else if (reg_hit(paddr, IDX_INT_MASK)) begin
            rd_nxt[1:0] = int_mask_r;
        end
        // prescaler settings are write-only and read as zero
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata_r <= rd_nxt;
        end
    end

endmodule : dual_prescaled_counter_timers

// ==== dual_timer_pkg.sv ====
// dual_timer_pkg: register indices, field positions, reset values and
// modes shared by the dual prescaled counter/timer block.
// assumes an apb slave with register index times four as byte address.
package dual_timer_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is index * 4)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_TIMER_MODE = 8'hf1;
    localparam logic [7:0] IDX_COUNTER_B = 8'hf2;
    localparam logic [7:0] IDX_PRESCALER_B = 8'hf3;
    localparam logic [7:0] IDX_COUNTER_A = 8'hf4;
    localparam logic [7:0] IDX_PRESCALER_A = 8'hf5;
    localparam logic [7:0] IDX_INT_STATUS = 8'hf6;
    localparam logic [7:0] IDX_INT_MASK = 8'hf7;

    // ------------------------------------------------------------
    // timer_mode fields
    // ------------------------------------------------------------
    localparam int TM_LOAD_A = 0;
    localparam int TM_EN_A = 1;
    localparam int TM_LOAD_B = 2;
    localparam int TM_EN_B = 3;
    localparam int TM_INMODE_LSB = 4;
    localparam int TM_INMODE_MSB = 5;

    // ------------------------------------------------------------
    // prescaler setting fields
    // ------------------------------------------------------------
    localparam int PRE_CONT_BIT = 0;
    localparam int PRE_CLKSEL_BIT = 1;
    localparam int PRE_RATIO_LSB = 2;
    localparam int PRE_RATIO_MSB = 7;

    // ------------------------------------------------------------
    // interrupt bits
    // ------------------------------------------------------------
    localparam int INT_A_BIT = 0;
    localparam int INT_B_BIT = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TIMER_MODE_RST = 8'h00;
    localparam logic [7:0] PRESCALER_RST = 8'h00;
    localparam logic [7:0] COUNTER_INIT_RST = 8'h00;
    localparam logic [1:0] INT_RST = 2'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int INT_CLOCK_DIV = 4;

    typedef enum logic [1:0] {
        in_ext_clock,
        in_gate,
        in_trig_nonretrig,
        in_trig_retrig
    } ext_mode_t;

endpackage : dual_timer_pkg

// ==== prescaled_counter.sv ====
// prescaled_counter: one 6-bit prescaler feeding one 8-bit down-counter.
// assumes src_tick is a one-cycle pulse synchronous to pclk.
`timescale 1ns/1ps
module prescaled_counter #(
    parameter int CNT_W = 8,
    parameter int PRE_W = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src_tick,
    input wire logic run,
    input wire logic restart,
    input wire logic continuous,
    input wire logic [CNT_W-1:0] init_count,
    input wire logic [PRE_W-1:0] pre_ratio,
    output logic [CNT_W-1:0] count,
    output logic eoc
);

    logic [CNT_W-1:0] cnt_r;
    logic [PRE_W-1:0] pre_r;
    logic pre_pulse;

    // ------------------------------------------------------------
    // terminal detection
    // ------------------------------------------------------------
    // zero loaded wraps to all ones, so 0 counts as the full range
    assign pre_pulse = run && src_tick && (pre_r == PRE_W'(1));
    assign eoc = pre_pulse && (cnt_r == CNT_W'(1));
    assign count = cnt_r;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= '0;
        end else if (restart || pre_pulse) begin
            pre_r <= pre_ratio;
        end else if (run && src_tick) begin
            pre_r <= pre_r - PRE_W'(1);
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (restart) begin
            cnt_r <= init_count;
        end else if (eoc) begin
            cnt_r <= continuous ? init_count : '0;
        end else if (pre_pulse) begin
            cnt_r <= cnt_r - CNT_W'(1);
        end
    end

endmodule : prescaled_counter

// ==== ext_input_cond.sv ====
// ext_input_cond: builds the source tick and trigger restart for unit b
// from the internal divided clock and the external timer input.
// assumes external_timer_input is already synchronous to pclk.
`timescale 1ns/1ps
module ext_input_cond
    import dual_timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ext_in,
    input wire logic int_tick,
    input wire logic use_ext,
    input wire logic [1:0] mode,
    input wire logic enable,
    input wire logic eoc,
    input wire logic continuous,
    output logic src_tick,
    output logic restart
);

    ext_mode_t mode_e;
    logic prev_r;
    logic running_r;
    logic rise;
    logic fall;
    logic trig_mode;

    assign mode_e = ext_mode_t'(mode);
    assign rise = ext_in && !prev_r;
    assign fall = !ext_in && prev_r;
    assign trig_mode = !use_ext && (mode_e == in_trig_nonretrig || mode_e == in_trig_retrig);

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    always_comb begin
        if (use_ext) begin
            src_tick = rise;
        end else begin
            case (mode_e)
                in_gate: src_tick = int_tick && ext_in;
                in_trig_nonretrig: src_tick = int_tick && running_r;
                in_trig_retrig: src_tick = int_tick && running_r;
                default: src_tick = int_tick;
            endcase
        end
    end

    // non-retriggerable mode ignores edges while already counting
    assign restart = trig_mode && enable && fall && (mode_e == in_trig_retrig || !running_r);

    // ------------------------------------------------------------
    // edge history and trigger run state
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= ext_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_r <= 1'b0;
        end else if (!enable || !trig_mode) begin
            running_r <= 1'b0;
        end else if (restart) begin
            running_r <= 1'b1;
        end else if (eoc && !continuous) begin
            running_r <= 1'b0;
        end
    end

endmodule : ext_input_cond

// ==== dual_timer_checker.sv ====
// dual_timer_checker: port-level assertions for the dual counter/timer block.
// assumes an apb master that holds each request until pready; bound below.
`timescale 1ns/1ps
module dual_timer_checker
    import dual_timer_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic counter_a_interrupt,
    input wire logic counter_b_interrupt,
    input wire logic irq
);
    // ----
    // helpers and properties
    // ----
    logic acc;
    logic rd_acc;
    logic mapped;
    logic [7:0] idx;
    assign acc = psel && penable;
    assign rd_acc = acc && !pwrite;
    assign idx = paddr[9:2];
    assign mapped = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00) && (idx >= IDX_TIMER_MODE)
        && (idx <= IDX_INT_MASK);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    irq_source_a: assert property (irq |-> counter_a_interrupt || counter_b_interrupt)
        else $error("irq high with no unit pending");
    sticky_int_a_a: assert property (counter_a_interrupt && !(acc && pwrite && mapped && idx == IDX_INT_STATUS
        && pwdata[INT_A_BIT]) |=> counter_a_interrupt) else $error("unit a flag dropped without clear");
    sticky_int_b_a: assert property (counter_b_interrupt && !(acc && pwrite && mapped && idx == IDX_INT_STATUS
        && pwdata[INT_B_BIT]) |=> counter_b_interrupt) else $error("unit b flag dropped without clear");
    status_mirror_a: assert property (rd_acc && mapped && idx == IDX_INT_STATUS
        |-> prdata[1:0] == $past({counter_b_interrupt, counter_a_interrupt})) else $error("status read mismatch");
    unmapped_err_a: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr does not follow the map");
    err_idle_a: assert property (!acc |-> !pslverr)
        else $error("pslverr outside access phase");
    ready_access_a: assert property (acc |-> pready)
        else $error("access phase without pready");
    prescaler_hidden_a: assert property (rd_acc && mapped && (idx == IDX_PRESCALER_A || idx == IDX_PRESCALER_B)
        |-> prdata == 32'h0) else $error("prescaler readable");
    upper_zero_a: assert property (rd_acc |-> prdata[31:8] == 24'h0)
        else $error("read data above bit 7");
    load_selfclear_a: assert property (rd_acc && mapped && idx == IDX_TIMER_MODE
        |-> !prdata[TM_LOAD_A] && !prdata[TM_LOAD_B]) else $error("load bit not self-cleared");

    cover property ($rose(counter_a_interrupt));
    cover property ($rose(counter_b_interrupt));
    cover property (acc && pslverr);
endmodule : dual_timer_checker

bind dual_prescaled_counter_timers dual_timer_checker #(.ADDR_W(ADDR_W)) chk_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .counter_a_interrupt(counter_a_interrupt),
    .counter_b_interrupt(counter_b_interrupt),
    .irq(irq)
);

// ==== ext_pin_model.sv ====
// ext_pin_model: source on the external timer input pin, bursts of pulses.
// assumes a new burst is requested only after the last one ended.
`timescale 1ns/1ps
module ext_pin_model (
    input wire logic pclk,
    input wire logic start,
    input wire logic [7:0] n_pulses,
    input wire logic [3:0] half,
    output logic pin
);
    // ----
    // pulse burst
    // ----
    logic busy;
    initial begin
        pin = 1'b0;
        busy = 1'b0;
    end
    // idle low between bursts, so a stray level never looks like a clock
    always @(posedge pclk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            for (int i = 0; i < 2 * n_pulses; i++) begin
                repeat (half) @(posedge pclk);
                pin <= ~pin;
            end
            busy <= 1'b0;
        end
    end
endmodule : ext_pin_model

// ==== dual_prescaled_counter_timers_test.sv ====
// dual_prescaled_counter_timers_test: self-checking bench for the dual timers.
// assumes the apb slave and ext_pin_model on the timer input pin.
`timescale 1ns/1ps
module dual_prescaled_counter_timers_test
    import dual_timer_pkg::*;
;
    // ----
    // bench
    // ----
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic ext_pin, ia, ib, irq, ep_start;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] ep_n;
    logic [32:0] exp_q[$];
    int n_mismatch = 0;
    int compares = 0;
    int seed = 86;
    int cyc = 0;

    dual_prescaled_counter_timers dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_timer_input(ext_pin), .counter_a_interrupt(ia), .counter_b_interrupt(ib), .irq(irq));
    ext_pin_model ep_u (.pclk(pclk), .start(ep_start), .n_pulses(ep_n), .half(4'h3), .pin(ext_pin));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // reads note {pslverr, prdata} expected; the monitor compares at completion
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d, input logic [32:0] e);
        if (!w) exp_q.push_back(e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, i, {24'h0, d}, 33'h0);
    endtask : wr

    task automatic rd(input logic [7:0] i, input logic [32:0] e);
        apb(1'b0, i, 32'h0, e);
    endtask : rd

    task automatic wait_int(input bit b, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((b ? ib : ia) !== 1'b1 && n < lim);
        if (n >= lim) chk(33'h0, 33'h1);
    endtask : wait_int

    // two pin pulses, falls 6 cycles apart; count 4 at ratio 1 outlasts the gap
    task automatic trig(input logic [7:0] tm, input bit late);
        int t0;
        wr(IDX_INT_STATUS, 8'h02);
        wr(IDX_TIMER_MODE, tm);
        ep_n <= 8'd2;
        ep_start <= 1'b1;
        t0 = cyc;
        @(posedge pclk);
        ep_start <= 1'b0;
        wait_int(1'b1, 60);
        chk(33'(cyc - t0 >= 28), {32'h0, late});
        rd(IDX_TIMER_MODE, {25'h0, tm});
    endtask : trig

    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) chk(33'h0, 33'h1);
            else chk({pslverr, prdata}, exp_q.pop_front());
        end
    end

    initial begin
        #400000;
        n_mismatch++;
        results();
    end

    initial begin
        logic [5:0] r;
        logic [7:0] c;
        int p, t0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ep_start = 1'b0;
        ep_n = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd(8'(IDX_TIMER_MODE + i), 33'h0);
        rd(8'h10, {1'b1, 32'h0});
        wr(8'h10, 8'hff);
        wr(IDX_PRESCALER_B, 8'hfe);
        rd(IDX_PRESCALER_B, 33'h0);
        // single pass: random, max prescale, max count; bit1 low but a stays internal
        for (int k = 0; k < 3; k++) begin
            r = (k == 0) ? 6'(1 + ($random(seed) & 1)) : ((k == 1) ? 6'h00 : 6'h01);
            c = (k == 0) ? 8'(1 + ($random(seed) & 3)) : ((k == 1) ? 8'h01 : 8'h00);
            p = ((r == 0) ? 64 : int'(r)) * ((c == 0) ? 256 : int'(c)) * INT_CLOCK_DIV;
            wr(IDX_PRESCALER_A, {r, 2'b00});
            wr(IDX_COUNTER_A, c);
            wr(IDX_TIMER_MODE, 8'h03);
            t0 = cyc;
            wait_int(1'b0, p + 20);
            chk(33'(cyc - t0 >= p - 4 && cyc - t0 <= p + 4), 33'h1);
            rd(IDX_COUNTER_A, 33'h0);
            rd(IDX_TIMER_MODE, 33'h0);
            rd(IDX_INT_STATUS, 33'h1);
            wr(IDX_INT_STATUS, 8'h01);
        end
        // continuous: ratio 1, count 2 gives a flag every 8 cycles
        wr(IDX_PRESCALER_A, 8'h05);
        wr(IDX_COUNTER_A, 8'h02);
        wr(IDX_TIMER_MODE, 8'h03);
        wait_int(1'b0, 40);
        t0 = cyc;
        wr(IDX_INT_STATUS, 8'h01);
        wait_int(1'b0, 40);
        chk(33'(cyc - t0), 33'd8);
        @(negedge pclk);
        chk({32'h0, irq}, 33'h0);
        wr(IDX_INT_MASK, 8'h01);
        @(negedge pclk);
        chk({32'h0, irq}, 33'h1);
        wr(IDX_TIMER_MODE, 8'h01);
        wr(IDX_INT_STATUS, 8'h01);
        @(negedge pclk);
        chk({32'h0, irq}, 33'h0);
        repeat (20) @(posedge pclk);
        rd(IDX_COUNTER_A, 33'h2);
        // unit b on external edges: nothing moves until the pin pulses
        wr(IDX_PRESCALER_B, 8'h04);
        wr(IDX_COUNTER_B, 8'h02);
        wr(IDX_TIMER_MODE, 8'h0c);
        repeat (12) @(posedge pclk);
        rd(IDX_COUNTER_B, 33'h2);
        ep_n <= 8'd2;
        ep_start <= 1'b1;
        @(posedge pclk);
        ep_start <= 1'b0;
        wait_int(1'b1, 60);
        rd(IDX_COUNTER_B, 33'h0);
        rd(IDX_INT_STATUS, 33'h2);
        // gate mode with the pin low holds the count
        wr(IDX_PRESCALER_B, 8'h06);
        wr(IDX_TIMER_MODE, 8'h1c);
        repeat (20) @(posedge pclk);
        rd(IDX_COUNTER_B, 33'h2);
        // trigger modes: the second fall is ignored, then restarts the count
        wr(IDX_COUNTER_B, 8'h04);
        trig(8'h28, 1'b0);
        trig(8'h38, 1'b1);
        repeat (3) @(posedge pclk);
        results();
    end
endmodule : dual_prescaled_counter_timers_test
